// *** logic/irq_ctrl_consts.vh ***
// Constants for the four-level interrupt controller
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_ENABLE_MAIN     10'h0A8
`define IDX_ENABLE_EXT      10'h0B1
`define IDX_PRIO_LOW_EXT    10'h0B2
`define IDX_PRIO_HIGH_EXT   10'h0B3
`define IDX_PRIO_HIGH_MAIN  10'h0B7
`define IDX_PRIO_LOW_MAIN   10'h0B8
`define IDX_STATUS          10'h0C0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_ENABLE_MAIN     8'h00
`define RST_ENABLE_EXT      2'h0
`define RST_PRIO_MAIN       7'h00
`define RST_PRIO_EXT        2'h0

// ----------------------------------------------------------------
// Enable register fields
// ----------------------------------------------------------------
`define BIT_GLOBAL_EN       7
`define BIT_CA_EN           6
`define BIT_T2_EN           5
`define BIT_SER_EN          4
`define BIT_T1_EN           3
`define BIT_X1_EN           2
`define BIT_T0_EN           1
`define BIT_X0_EN           0
`define BIT_SPI_EN          2
`define BIT_KBD_EN          0

// ----------------------------------------------------------------
// Main and extension priority register fields (same positions high and low)
// ----------------------------------------------------------------
`define BIT_CA_PRIO         6
`define BIT_T2_PRIO         5
`define BIT_SER_PRIO        4
`define BIT_T1_PRIO         3
`define BIT_X1_PRIO         2
`define BIT_T0_PRIO         1
`define BIT_X0_PRIO         0
`define BIT_SPI_PRIO        2
`define BIT_KBD_PRIO        0
`define BIT_PRIO_RSVD       3'h7

// ----------------------------------------------------------------
// Sources in polling order, index 0 polled first
// ----------------------------------------------------------------
`define NUM_SOURCES         9
`define SRC_X0              4'h0
`define SRC_T0              4'h1
`define SRC_X1              4'h2
`define SRC_T1              4'h3
`define SRC_CA              4'h4
`define SRC_SER             4'h5
`define SRC_T2              4'h6
`define SRC_KBD             4'h7
`define SRC_SPI             4'h8

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define VEC_X0              16'h0003
`define VEC_T0              16'h000B
`define VEC_X1              16'h0013
`define VEC_T1              16'h001B
`define VEC_SER             16'h0023
`define VEC_T2              16'h002B
`define VEC_CA              16'h0033
`define VEC_KBD             16'h003B
`define VEC_SPI             16'h004B

`endif

// *** logic/priority_pick.v ***
// Selects the highest-level request, lowest index winning ties
`timescale 1ns/1ps
module priority_pick #(
	parameter N  = 9,
	parameter IW = 4
) (
	// Requests and their levels
	input  wire [N-1:0]   req,
	input  wire [2*N-1:0] lvl,
	// Winner
	output reg            found,
	output reg  [IW-1:0]  idx,
	output reg  [1:0]     level
);

	integer i;

	// Scan downward so a later equal-level hit overrides
	always @* begin
		found = 1'b0;
		idx   = {IW{1'b0}};
		level = 2'h0;
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req[i] && (!found || lvl[2*i +: 2] >= level)) begin
				found = 1'b1;
				idx   = i[IW-1:0];
				level = lvl[2*i +: 2];
			end
		end
	end

endmodule

// *** logic/four_level_interrupt_controller.v ***
// Nine-source four-level interrupt controller with APB registers
`timescale 1ns/1ps
`include "irq_ctrl_consts.vh"
module four_level_interrupt_controller (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Core single-bit register access
	input  wire        bit_wr,
	input  wire [7:0]  bit_index,
	input  wire [2:0]  bit_pos,
	input  wire        bit_value,
	// Peripheral request flags, polling order
	input  wire [8:0]  src_flag,
	// Core interrupt handshake
	input  wire        irq_ack,
	input  wire        irq_return,
	output reg         irq_req,
	output reg  [15:0] irq_vector,
	output reg  [1:0]  irq_level,
	output reg  [3:0]  irq_source
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	reg  [7:0] interrupt_enable_main;
	reg  [1:0] interrupt_enable_extension;
	reg  [6:0] irq_priority_low_main;
	reg  [6:0] irq_priority_high_main;
	reg  [1:0] irq_priority_low_ext;
	reg  [1:0] irq_priority_high_ext;
	reg  [3:0] in_service;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire [9:0] addr_idx;
	wire       aligned;
	wire       apb_setup;
	wire       apb_access;
	wire       apb_wr;
	reg        addr_hit;
	reg  [7:0] read_byte;

	assign addr_idx   = paddr[11:2];
	assign aligned    = (paddr[1:0] == 2'h0);
	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	// Zero wait states; lane 0 carries all register bits
	assign apb_wr     = apb_access & pwrite & addr_hit & pstrb[0];
	assign pready     = 1'b1;
	assign pslverr    = apb_access & ~addr_hit;

	// reserved bits read as zero here
	always @* begin
		addr_hit  = aligned;
		read_byte = 8'h00;
		case (addr_idx)
			`IDX_ENABLE_MAIN: begin
				read_byte = interrupt_enable_main;
			end
			`IDX_ENABLE_EXT: begin
				read_byte[`BIT_SPI_EN] = interrupt_enable_extension[1];
				read_byte[`BIT_KBD_EN] = interrupt_enable_extension[0];
			end
			`IDX_PRIO_LOW_EXT: begin
				read_byte[`BIT_SPI_PRIO] = irq_priority_low_ext[1];
				read_byte[`BIT_KBD_PRIO] = irq_priority_low_ext[0];
			end
			`IDX_PRIO_HIGH_EXT: begin
				read_byte[`BIT_SPI_PRIO] = irq_priority_high_ext[1];
				read_byte[`BIT_KBD_PRIO] = irq_priority_high_ext[0];
			end
			`IDX_PRIO_HIGH_MAIN: begin
				read_byte = {1'b0, irq_priority_high_main};
			end
			`IDX_PRIO_LOW_MAIN: begin
				read_byte = {1'b0, irq_priority_low_main};
			end
			`IDX_STATUS: begin
				read_byte = {irq_req, 3'h0, in_service};
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// Read data captured in setup so it is stable through access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (apb_setup && !pwrite) begin
			// Refused addresses return zero, even misaligned hits
			prdata <= {24'h000000, addr_hit ? read_byte : 8'h00};
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_main      <= `RST_ENABLE_MAIN;
			interrupt_enable_extension <= `RST_ENABLE_EXT;
			irq_priority_low_main      <= `RST_PRIO_MAIN;
			irq_priority_high_main     <= `RST_PRIO_MAIN;
			irq_priority_low_ext       <= `RST_PRIO_EXT;
			irq_priority_high_ext      <= `RST_PRIO_EXT;
		end else if (apb_wr) begin
			// APB wins over a same-cycle bit write
			case (addr_idx)
				`IDX_ENABLE_MAIN: begin
					interrupt_enable_main <= pwdata[7:0];
				end
				`IDX_ENABLE_EXT: begin
					interrupt_enable_extension <= {pwdata[`BIT_SPI_EN], pwdata[`BIT_KBD_EN]};
				end
				`IDX_PRIO_LOW_EXT: begin
					irq_priority_low_ext <= {pwdata[`BIT_SPI_PRIO], pwdata[`BIT_KBD_PRIO]};
				end
				`IDX_PRIO_HIGH_EXT: begin
					irq_priority_high_ext <= {pwdata[`BIT_SPI_PRIO], pwdata[`BIT_KBD_PRIO]};
				end
				`IDX_PRIO_HIGH_MAIN: begin
					irq_priority_high_main <= pwdata[6:0];
				end
				`IDX_PRIO_LOW_MAIN: begin
					irq_priority_low_main <= pwdata[6:0];
				end
				default: begin
				end
			endcase
		end else if (bit_wr) begin
			// bit access: high priority registers refuse it
			case ({2'h0, bit_index})
				`IDX_ENABLE_MAIN: begin
					interrupt_enable_main[bit_pos] <= bit_value;
				end
				`IDX_PRIO_LOW_MAIN: begin
					if (bit_pos != `BIT_PRIO_RSVD) begin
						irq_priority_low_main[bit_pos] <= bit_value;
					end
				end
				`IDX_PRIO_LOW_EXT: begin
					if (bit_pos == `BIT_SPI_PRIO) begin
						irq_priority_low_ext[1] <= bit_value;
					end else if (bit_pos == `BIT_KBD_PRIO) begin
						irq_priority_low_ext[0] <= bit_value;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Per-source enable and level, polling order
	// ----------------------------------------------------------------
	wire [8:0]  src_enable;
	wire [8:0]  prio_high;
	wire [8:0]  prio_low;
	wire [8:0]  eligible;
	wire [17:0] src_level;
	wire        global_irq_enable;

	assign src_enable = {
		interrupt_enable_extension[1],
		interrupt_enable_extension[0],
		interrupt_enable_main[`BIT_T2_EN],
		interrupt_enable_main[`BIT_SER_EN],
		interrupt_enable_main[`BIT_CA_EN],
		interrupt_enable_main[`BIT_T1_EN],
		interrupt_enable_main[`BIT_X1_EN],
		interrupt_enable_main[`BIT_T0_EN],
		interrupt_enable_main[`BIT_X0_EN]
	};

	// same positions in both priority registers
	assign prio_high = {
		irq_priority_high_ext[1],
		irq_priority_high_ext[0],
		irq_priority_high_main[`BIT_T2_PRIO],
		irq_priority_high_main[`BIT_SER_PRIO],
		irq_priority_high_main[`BIT_CA_PRIO],
		irq_priority_high_main[`BIT_T1_PRIO],
		irq_priority_high_main[`BIT_X1_PRIO],
		irq_priority_high_main[`BIT_T0_PRIO],
		irq_priority_high_main[`BIT_X0_PRIO]
	};
	assign prio_low = {
		irq_priority_low_ext[1],
		irq_priority_low_ext[0],
		irq_priority_low_main[`BIT_T2_PRIO],
		irq_priority_low_main[`BIT_SER_PRIO],
		irq_priority_low_main[`BIT_CA_PRIO],
		irq_priority_low_main[`BIT_T1_PRIO],
		irq_priority_low_main[`BIT_X1_PRIO],
		irq_priority_low_main[`BIT_T0_PRIO],
		irq_priority_low_main[`BIT_X0_PRIO]
	};

	assign global_irq_enable = interrupt_enable_main[`BIT_GLOBAL_EN];

	genvar g;
	generate
		for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : gen_src
			assign src_level[2*g +: 2] = {prio_high[g], prio_low[g]};
			// flag gated by own and global enable
			assign eligible[g] = src_flag[g] & src_enable[g] & global_irq_enable;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration
	// ----------------------------------------------------------------
	wire       pick_found;
	wire [3:0] pick_idx;
	wire [1:0] pick_level;

	// higher level first, then polling order
	priority_pick #(
		.N  (9),
		.IW (4)
	) u_pick (
		.req   (eligible),
		.lvl   (src_level),
		.found (pick_found),
		.idx   (pick_idx),
		.level (pick_level)
	);

	// ----------------------------------------------------------------
	// In-service tracking
	// ----------------------------------------------------------------
	reg  [3:0] next_in_service;
	reg        busy;
	reg  [1:0] busy_level;
	reg        next_irq_req;
	integer    k;

	// Return retires the highest active level; ack opens the taken level
	always @* begin
		next_in_service = in_service;
		if (irq_return) begin
			if (in_service[3]) begin
				next_in_service[3] = 1'b0;
			end else if (in_service[2]) begin
				next_in_service[2] = 1'b0;
			end else if (in_service[1]) begin
				next_in_service[1] = 1'b0;
			end else begin
				next_in_service[0] = 1'b0;
			end
		end
		if (irq_ack && irq_req) begin
			next_in_service[irq_level] = 1'b1;
		end
	end

	// Uses the next value so the request drops right after an ack
	always @* begin
		busy       = 1'b0;
		busy_level = 2'h0;
		for (k = 0; k < 4; k = k + 1) begin
			if (next_in_service[k]) begin
				busy       = 1'b1;
				busy_level = k[1:0];
			end
		end
		// strictly above every level in service
		next_irq_req = pick_found && (!busy || (pick_level > busy_level));
	end

	function [15:0] vector_of;
		input [3:0] idx;
		begin
			case (idx)
				`SRC_X0:  vector_of = `VEC_X0;
				`SRC_T0:  vector_of = `VEC_T0;
				`SRC_X1:  vector_of = `VEC_X1;
				`SRC_T1:  vector_of = `VEC_T1;
				`SRC_CA:  vector_of = `VEC_CA;
				`SRC_SER: vector_of = `VEC_SER;
				`SRC_T2:  vector_of = `VEC_T2;
				`SRC_KBD: vector_of = `VEC_KBD;
				`SRC_SPI: vector_of = `VEC_SPI;
				default:  vector_of = 16'h0000;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Core-facing outputs
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_service <= 4'h0;
			irq_req    <= 1'b0;
			irq_vector <= 16'h0000;
			irq_level  <= 2'h0;
			irq_source <= 4'h0;
		end else begin
			in_service <= next_in_service;
			irq_req    <= next_irq_req;
			irq_vector <= next_irq_req ? vector_of(pick_idx) : 16'h0000;
			irq_level  <= next_irq_req ? pick_level : 2'h0;
			irq_source <= next_irq_req ? pick_idx : 4'h0;
		end
	end

endmodule

// *** testbench/irq_ctrl_assertions.sv ***
// Port-level assertions for the four-level interrupt controller
`timescale 1ns/1ps
module irq_ctrl_assertions (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// Register bus
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire        pready,
	input wire        pslverr,
	// Core side
	input wire [8:0]  src_flag,
	input wire        irq_ack,
	input wire        irq_return,
	input wire        irq_req,
	input wire [15:0] irq_vector,
	input wire [1:0]  irq_level,
	input wire [3:0]  irq_source
);
	// Vectors in polling order, index 0 lowest
	localparam logic [143:0] VT = {16'h004B, 16'h003B, 16'h002B, 16'h0023, 16'h0033, 16'h001B, 16'h0013,
		16'h000B, 16'h0003};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_always_a: assert property (pready) else $error("pready low");
	err_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	idle_zero_a: assert property (!irq_req |-> irq_vector == 16'h0 && irq_level == 2'h0 && irq_source == 4'h0)
		else $error("idle outputs not zero");
	vector_map_a: assert property (irq_req |-> irq_vector == VT[irq_source*16+:16])
		else $error("vector does not match source");
	flag_cause_a: assert property (irq_req |-> |($past(src_flag) & (9'h1 << irq_source)))
		else $error("request without source flag");
	no_flag_idle_a: assert property (src_flag == 9'h0 |=> !irq_req) else $error("request with no flags");
	ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req || irq_level > $past(irq_level))
		else $error("same level preempts");
	top_block_a: assert property (irq_req && irq_ack && irq_level == 2'h3 && !irq_return |=> !irq_req [*4])
		else $error("top level preempted");
endmodule

bind four_level_interrupt_controller irq_ctrl_assertions i_chk (.pclk, .presetn, .psel, .penable, .paddr,
	.pready, .pslverr, .src_flag, .irq_ack, .irq_return, .irq_req, .irq_vector, .irq_level, .irq_source);

// *** testbench/core_model.sv ***
// Processor core model: takes presented interrupts and retires routines
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire        pclk,
	input wire        presetn,
	// Bench control
	input wire        take,
	input wire [1:0]  lag,
	input wire        retire,
	// Controller handshake
	input wire        irq_req,
	output logic      irq_ack,
	output logic      irq_return
);
	logic [1:0] wait_cnt;

	// Ack only while a request stands, after lag cycles; never twice in a row
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= 1'b0;
			irq_return <= 1'b0;
			wait_cnt <= 2'h0;
		end else begin
			irq_return <= retire;
			irq_ack <= 1'b0;
			if (take && irq_req && !irq_ack) begin
				if (wait_cnt == lag) begin
					irq_ack <= 1'b1;
					wait_cnt <= 2'h0;
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end
		end
	end
endmodule

// *** testbench/four_level_interrupt_controller_test.sv ***
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_consts.vh"
module four_level_interrupt_controller_test;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bit_wr = 0, bit_value = 0;
	logic        irq_ack, irq_return, irq_req, pready, pslverr, take = 0, retire = 0, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'h4DCD2B10;
	logic [3:0]  pstrb = 4'hF, st = 4'hF, irq_source;
	logic [7:0]  bit_index = 0;
	logic [2:0]  bit_pos = 0;
	logic [8:0]  src_flag = 0;
	logic [15:0] irq_vector;
	logic [1:0]  irq_level, lag = 0, mis = 0;
	logic [7:0]  sh [6];
	int          errors = 0, checks_done = 0;
	localparam logic [143:0] VT = {16'h004B, 16'h003B, 16'h002B, 16'h0023, 16'h0033, 16'h001B, 16'h0013,
		16'h000B, 16'h0003};
	localparam logic [26:0] BP = {3'h2, 3'h0, 3'h5, 3'h4, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
	localparam logic [59:0] IX = {`IDX_PRIO_HIGH_EXT, `IDX_PRIO_LOW_EXT, `IDX_PRIO_HIGH_MAIN, `IDX_PRIO_LOW_MAIN,
		`IDX_ENABLE_EXT, `IDX_ENABLE_MAIN};

	always #50 pclk = ~pclk;
	four_level_interrupt_controller i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .bit_wr, .bit_index, .bit_pos, .bit_value, .src_flag, .irq_ack, .irq_return,
		.irq_req, .irq_vector, .irq_level, .irq_source);
	core_model i_core (.pclk, .presetn, .take, .lag, .retire, .irq_req, .irq_ack, .irq_return);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected winner: highest level, lowest polling index on ties
	function automatic void pick(input logic [8:0] f, output logic r, output logic [3:0] s, output logic [1:0] l);
		logic [2:0] b;
		logic [1:0] v;
		r = 0;
		s = 0;
		l = 0;
		for (int i = 0; i < 9; i++) begin
			b = BP[i*3+:3];
			v = {sh[i < 7 ? 3 : 5][b], sh[i < 7 ? 2 : 4][b]};
			if (f[i] && sh[0][7] && sh[i < 7 ? 0 : 1][b] && (!r || v > l)) begin
				r = 1;
				s = i[3:0];
				l = v;
			end
		end
	endfunction

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chk_irq(input logic r, input logic [3:0] s, input logic [1:0] l);
		chk({9'h0, irq_req, irq_level, irq_source, irq_vector}, r ? {9'h0, 1'b1, l, s, VT[s*16+:16]} : 32'h0);
	endtask
	task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, mis};
		pwdata <= {24'h0, d};
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task bitw(input logic [7:0] idx, input logic [2:0] p, input logic v);
		@(posedge pclk);
		bit_wr <= 1'b1;
		bit_index <= idx;
		bit_pos <= p;
		bit_value <= v;
		@(posedge pclk);
		bit_wr <= 1'b0;
	endtask
	task settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task flags(input logic [8:0] f);
		logic r;
		logic [3:0] s;
		logic [1:0] l;
		@(posedge pclk);
		src_flag <= f;
		settle(2);
		pick(f, r, s, l);
	endtask
	task load();
		for (int k = 0; k < 6; k++) apb(1, IX[k*10+:10], sh[k]);
	endtask
	task rall();
		for (int k = 0; k < 6; k++) begin
			apb(0, IX[k*10+:10], 8'h0);
			chk(rd, {24'h0, sh[k]});
		end
	endtask
	task serve();
		@(posedge pclk);
		lag <= 2'(rnd());
		take <= 1'b1;
		do begin
			@(posedge pclk);
		end while (irq_ack !== 1'b1);
		take <= 1'b0;
		settle(2);
	endtask
	task pulse_retire();
		@(posedge pclk);
		retire <= 1'b1;
		@(posedge pclk);
		retire <= 1'b0;
		settle(3);
	endtask
	task print_verdict();
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		#2000000;
		errors++;
		print_verdict();
	end

	initial begin
		logic r;
		logic [3:0] s;
		logic [1:0] l;
		logic [8:0] f;
		foreach (sh[k]) sh[k] = 8'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rall();
		// Reserved bits written as zero
		sh[0] = 8'(rnd());
		sh[1] = 8'(rnd() & 8'h05);
		sh[2] = 8'(rnd() & 8'h7F);
		sh[3] = 8'(rnd() & 8'h7F);
		load();
		st = 4'h0;
		apb(1, IX[0+:10], ~sh[0]);
		st = 4'hF;
		bitw(8'hA8, 3'h3, ~sh[0][3]);
		sh[0][3] = ~sh[0][3];
		bitw(8'hB8, 3'h4, 1'b1);
		sh[2][4] = 1'b1;
		bitw(8'hB7, 3'h0, ~sh[3][0]);
		bitw(8'hB2, 3'h2, 1'b1);
		sh[4][2] = 1'b1;
		bitw(8'hB8, 3'h7, 1'b1);
		rall();
		apb(0, 10'h0A9, 8'h0);
		chk({rd[30:0], er}, 32'h1);
		mis = 2'h1;
		apb(0, IX[0+:10], 8'h0);
		chk({rd[30:0], er}, 32'h1);
		mis = 2'h0;
		$display("test registers done");
		for (int i = 0; i < 9; i++) begin
			for (int m = 0; m < 3; m++) begin
				sh[0] = 8'hFF;
				sh[1] = 8'h05;
				if (m == 1) sh[i < 7 ? 0 : 1][BP[i*3+:3]] = 1'b0;
				if (m == 2) sh[0][7] = 1'b0;
				load();
				f = 9'h1 << i;
				flags(f);
				pick(f, r, s, l);
				chk_irq(r, s, l);
			end
		end
		$display("test sources done");
		repeat (40) begin
			sh[0] = 8'(rnd() | 8'h80);
			sh[1] = 8'(rnd() & 8'h05);
			for (int k = 2; k < 6; k++) sh[k] = 8'(rnd() & (k < 4 ? 8'h7F : 8'h05));
			load();
			f = 9'(rnd());
			flags(f);
			pick(f, r, s, l);
			chk_irq(r, s, l);
		end
		$display("test arbitration done");
		sh = '{8'hFF, 8'h05, 8'h0B, 8'h0C, 8'h00, 8'h00};
		load();
		flags(9'h001);
		chk_irq(1, 4'h0, 2'h1);
		serve();
		chk_irq(0, 4'h0, 2'h0);
		flags(9'h003);
		chk_irq(0, 4'h0, 2'h0);
		flags(9'h007);
		chk_irq(1, 4'h2, 2'h2);
		serve();
		flags(9'h00F);
		chk_irq(1, 4'h3, 2'h3);
		serve();
		flags(9'h1FF);
		chk_irq(0, 4'h0, 2'h0);
		apb(0, `IDX_STATUS, 8'h0);
		chk(rd, 32'h0000000E);
		pulse_retire();
		chk_irq(1, 4'h3, 2'h3);
		$display("test nesting done");
		print_verdict();
	end
endmodule
